// ### include/commutator_pkg.sv
/*
 Shared constants and types for the matrix commutator and the
 successive-approximation coder.
 Assumes a single 20 MHz clock; all times are converted to cycles here.
*/
`default_nettype none

package commutator_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

	// Saturating width of arm and strobe pulses
	localparam int SAT_PULSE_NS = 1000;
	localparam int SAT_PULSE_CYC = (SAT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Quiet time before each row strobe
	localparam int STROBE_GAP_NS = 1500;
	localparam int STROBE_GAP_CYC = (STROBE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Spacing of code step pulses, comparator settling
	localparam int STEP_PERIOD_NS = 500;
	localparam int STEP_PERIOD_CYC = (STEP_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Geometry defaults
	// ------------------------------------------------------------
	localparam int COLS_DEFAULT = 4;
	localparam int ROWS_DEFAULT = 8;
	localparam int BITS_DEFAULT = 8;

	// Step index that starts a conversion
	localparam int START_STEP = 0;

	// ------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ARM,
		ST_GAP,
		ST_READ,
		ST_CONV
	} seq_state_t;

endpackage

`default_nettype wire

// ### hdl/gate_matrix.sv
/*
 Digital model of the gate-core matrix: one core per channel gate plus an
 optional sequencer column, with the gate drives they produce.
 Assumes arm and strobe inputs are registered pulses from the sequencer.
*/
`default_nettype none

module gate_matrix
	import commutator_pkg::*;
#(
	parameter int COLS = COLS_DEFAULT,
	parameter int ROWS = ROWS_DEFAULT,
	parameter bit HAS_SEQ = 1'b1
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [COLS-1:0] col_arm,
	input wire logic seq_arm,
	input wire logic [ROWS-1:0] row_strobe,
	output logic [COLS*ROWS-1:0] gate_pos,
	output logic [COLS*ROWS-1:0] gate_neg,
	output logic [ROWS-1:0] seq_gate_pos,
	output logic [ROWS-1:0] seq_gate_neg
);

	// ------------------------------------------------------------
	// Cores and drives, sequencer column at index COLS
	// ------------------------------------------------------------
	logic [COLS:0][ROWS-1:0] core_ff;
	logic [COLS:0][ROWS-1:0] drive_ff;
	logic [COLS:0] arm_all;

	assign arm_all = {seq_arm & HAS_SEQ, col_arm};

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			core_ff <= '0;
			drive_ff <= '0;
		end else begin
			for (int c = 0; c <= COLS; c++) begin
				for (int r = 0; r < ROWS; r++) begin
					// Arming wins, a strobe drains the core
					core_ff[c][r] <= arm_all[c] | (core_ff[c][r] & ~row_strobe[r]);
					// Conducts only on the strobe that drains a set core
					drive_ff[c][r] <= row_strobe[r] & (core_ff[c][r] | drive_ff[c][r]);
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Both switches of a gate share one drive
	// ------------------------------------------------------------
	for (genvar c = 0; c < COLS; c++) begin : g_col
		assign gate_pos[c*ROWS +: ROWS] = drive_ff[c];
		assign gate_neg[c*ROWS +: ROWS] = drive_ff[c];
	end
	assign seq_gate_pos = drive_ff[COLS];
	assign seq_gate_neg = drive_ff[COLS];

endmodule

`default_nettype wire

// ### hdl/sar_coder.sv
/*
 Successive-approximation coder: current-switch flip-flops and output word,
 advanced by code step pulses.
 Assumes step pulses are one cycle wide and at least two cycles apart.
*/
`default_nettype none

module sar_coder
	import commutator_pkg::*;
#(
	parameter int BITS = BITS_DEFAULT,
	parameter int IW = $clog2(BITS + 1)
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic code_step_pulse,
	input wire logic [IW-1:0] step_idx,
	input wire logic err_pos,
	output logic [BITS-1:0] switch_on,
	output logic [BITS-1:0] code_word,
	output logic code_valid
);

	// ------------------------------------------------------------
	// Decision delay and step decode
	// ------------------------------------------------------------
	logic dec_ff;
	logic [BITS-1:0] sw_ff;
	logic [BITS-1:0] word_ff;
	logic valid_ff;
	logic [BITS-1:0] nxt_sw;
	logic [BITS-1:0] nxt_word;
	wire start_step = code_step_pulse && step_idx == IW'(START_STEP);
	wire set_cmd = code_step_pulse && !start_step && dec_ff;
	wire last_step = code_step_pulse && step_idx == IW'(BITS);

	always_comb begin
		nxt_sw = sw_ff;
		nxt_word = word_ff;
		if (start_step) begin
			nxt_sw = {1'b0, {(BITS-1){1'b1}}};
			nxt_word = '0;
		end else if (code_step_pulse) begin
			for (int k = 1; k <= BITS; k++) begin
				if (step_idx == IW'(k)) begin
					if (set_cmd) begin
						nxt_word[BITS-k] = 1'b1;
						nxt_sw[BITS-k] = 1'b1;
					end
					if (k < BITS)
						nxt_sw[BITS-k-1] = 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dec_ff <= 1'b0;
			sw_ff <= '0;
			word_ff <= '0;
			valid_ff <= 1'b0;
		end else begin
			// Settled result of the previous step, read at the next one
			dec_ff <= err_pos;
			sw_ff <= nxt_sw;
			word_ff <= nxt_word;
			valid_ff <= last_step;
		end
	end

	assign switch_on = sw_ff;
	assign code_word = word_ff;
	assign code_valid = valid_ff;

endmodule

`default_nettype wire

// ### hdl/matrix_commutator_sar_coder.sv
/*
 Top of the commutator and coder: frame sequencer, step pulse source,
 gate-core matrix and successive-approximation coder.
 Assumes run, super-commutation controls and the comparator input are
 synchronous to clk; analog parts sit outside.
*/
`default_nettype none

module matrix_commutator_sar_coder
	import commutator_pkg::*;
#(
	parameter int COLS = COLS_DEFAULT,
	parameter int ROWS = ROWS_DEFAULT,
	parameter int BITS = BITS_DEFAULT,
	parameter bit HAS_SEQ = 1'b1,
	parameter int PULSE_CYC = SAT_PULSE_CYC,
	parameter int GAP_CYC = STROBE_GAP_CYC,
	parameter int STEP_CYC = STEP_PERIOD_CYC
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic run,
	input wire logic super_en,
	input wire logic [COLS-1:0] super_cols,
	input wire logic err_pos,
	output logic [COLS-1:0] col_arm,
	output logic seq_col_arm,
	output logic [ROWS-1:0] row_strobe,
	output logic [COLS*ROWS-1:0] gate_pos,
	output logic [COLS*ROWS-1:0] gate_neg,
	output logic [ROWS-1:0] seq_gate_pos,
	output logic [ROWS-1:0] seq_gate_neg,
	output logic code_step_pulse,
	output logic [BITS-1:0] switch_on,
	output logic [BITS-1:0] code_word,
	output logic code_valid,
	output logic [COLS*ROWS-1:0] code_chan,
	output logic frame_start
);

	// ------------------------------------------------------------
	// Derived widths
	// ------------------------------------------------------------
	localparam int CW = (COLS > 1) ? $clog2(COLS) : 1;
	localparam int RW = (ROWS > 1) ? $clog2(ROWS) : 1;
	localparam int IW = $clog2(BITS + 1);
	localparam int TMAX = (PULSE_CYC > GAP_CYC) ? PULSE_CYC : GAP_CYC;
	localparam int TW = $clog2(TMAX + 1);
	localparam int DW = $clog2(STEP_CYC + 1);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (COLS < 1 || ROWS < 1)
		$error("matrix needs at least one column and one row");
	if (BITS < 2)
		$error("coder needs at least two bits");
	if (PULSE_CYC < 1 || STEP_CYC < 2)
		$error("pulse width or step spacing too short");
	// Arming must fit inside the quiet time before a strobe
	if (GAP_CYC < PULSE_CYC)
		$error("strobe gap shorter than an arm pulse");

	// ------------------------------------------------------------
	// One-hot decode helpers
	// ------------------------------------------------------------
	function automatic logic [COLS-1:0] col_mask(input logic [CW-1:0] idx);
		logic [COLS-1:0] m;
		m = '0;
		for (int i = 0; i < COLS; i++) begin
			if (idx == CW'(i))
				m[i] = 1'b1;
		end
		return m;
	endfunction

	function automatic logic [ROWS-1:0] row_mask(input logic [RW-1:0] idx);
		logic [ROWS-1:0] m;
		m = '0;
		for (int i = 0; i < ROWS; i++) begin
			if (idx == RW'(i))
				m[i] = 1'b1;
		end
		return m;
	endfunction

	// ------------------------------------------------------------
	// Sequencer registers
	// ------------------------------------------------------------
	seq_state_t state_ff;
	seq_state_t nxt_state;
	logic [TW-1:0] tmr_ff;
	logic [TW-1:0] nxt_tmr;
	logic [CW-1:0] col_ff;
	logic [CW-1:0] nxt_col;
	logic [RW-1:0] row_ff;
	logic [RW-1:0] nxt_row;
	logic rep_ff;
	logic nxt_rep;
	logic [DW-1:0] div_ff;
	logic [DW-1:0] nxt_div;
	logic [IW-1:0] conv_ff;
	logic [IW-1:0] nxt_conv;
	logic [COLS-1:0] col_arm_ff;
	logic seq_arm_ff;
	logic [ROWS-1:0] row_strobe_ff;
	logic step_pulse_ff;
	logic [IW-1:0] step_idx_ff;
	logic [COLS*ROWS-1:0] chan_ff;
	logic frame_ff;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire tmr_done = tmr_ff == '0;
	wire last_row = row_ff == RW'(ROWS - 1);
	wire last_col = col_ff == CW'(COLS - 1);
	// Second pass over a column only once per frame
	wire repeat_col = super_en && super_cols[col_ff] && !rep_ff;
	wire step_fire = state_ff == ST_CONV && div_ff == '0;
	wire conv_end = step_fire && conv_ff == IW'(BITS);
	wire frame_wrap = last_row && last_col && !repeat_col;
	wire [TW-1:0] pulse_load = TW'(PULSE_CYC - 1);
	wire [TW-1:0] gap_load = TW'(GAP_CYC - 1);
	wire [DW-1:0] div_load = DW'(STEP_CYC - 1);

	// ------------------------------------------------------------
	// Frame sequencer
	// ------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_tmr = tmr_ff;
		nxt_col = col_ff;
		nxt_row = row_ff;
		nxt_rep = rep_ff;
		nxt_div = div_ff;
		nxt_conv = conv_ff;
		case (state_ff)
			ST_IDLE: begin
				if (run) begin
					nxt_state = ST_ARM;
					nxt_tmr = pulse_load;
					nxt_col = '0;
					nxt_row = '0;
					nxt_rep = 1'b0;
				end
			end
			ST_ARM: begin
				nxt_tmr = tmr_ff - TW'(1);
				if (tmr_done) begin
					nxt_state = ST_GAP;
					nxt_tmr = gap_load;
				end
			end
			ST_GAP: begin
				nxt_tmr = tmr_ff - TW'(1);
				if (tmr_done) begin
					nxt_state = ST_READ;
					nxt_tmr = pulse_load;
				end
			end
			ST_READ: begin
				nxt_tmr = tmr_ff - TW'(1);
				if (tmr_done) begin
					nxt_state = ST_CONV;
					nxt_div = '0;
					nxt_conv = '0;
				end
			end
			ST_CONV: begin
				nxt_div = step_fire ? div_load : div_ff - DW'(1);
				if (step_fire)
					nxt_conv = conv_ff + IW'(1);
				if (conv_end) begin
					if (!last_row) begin
						// Stay on this column until every row is read
						nxt_row = row_ff + RW'(1);
						nxt_state = ST_GAP;
						nxt_tmr = gap_load;
					end else begin
						nxt_row = '0;
						if (repeat_col) begin
							nxt_rep = 1'b1;
						end else begin
							nxt_rep = 1'b0;
							nxt_col = last_col ? '0 : col_ff + CW'(1);
						end
						nxt_state = (frame_wrap && !run) ? ST_IDLE : ST_ARM;
						nxt_tmr = pulse_load;
					end
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= ST_IDLE;
			tmr_ff <= '0;
			col_ff <= '0;
			row_ff <= '0;
			rep_ff <= 1'b0;
			div_ff <= '0;
			conv_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			tmr_ff <= nxt_tmr;
			col_ff <= nxt_col;
			row_ff <= nxt_row;
			rep_ff <= nxt_rep;
			div_ff <= nxt_div;
			conv_ff <= nxt_conv;
		end
	end

	// ------------------------------------------------------------
	// Registered pulse outputs
	// ------------------------------------------------------------
	// Arm, strobe and frame outputs are built from next state so pulses start with the state; the step pulse follows step_fire a cycle later
	wire arm_next = nxt_state == ST_ARM;
	wire read_next = nxt_state == ST_READ;
	wire frame_next = arm_next && state_ff != ST_ARM && nxt_col == '0 && !nxt_rep;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			col_arm_ff <= '0;
			seq_arm_ff <= 1'b0;
			row_strobe_ff <= '0;
			step_pulse_ff <= 1'b0;
			step_idx_ff <= '0;
			chan_ff <= '0;
			frame_ff <= 1'b0;
		end else begin
			col_arm_ff <= arm_next ? col_mask(nxt_col) : '0;
			seq_arm_ff <= arm_next && HAS_SEQ;
			row_strobe_ff <= read_next ? row_mask(nxt_row) : '0;
			step_pulse_ff <= step_fire;
			step_idx_ff <= step_fire ? conv_ff : step_idx_ff;
			frame_ff <= frame_next;
			// One-hot channel, bit column*ROWS+row, held through the conversion
			if (state_ff == ST_READ && tmr_done)
				chan_ff <= (COLS*ROWS)'(1) << (32'(col_ff) * ROWS + 32'(row_ff));
		end
	end

	// ------------------------------------------------------------
	// Gate-core matrix
	// ------------------------------------------------------------
	gate_matrix #(
		.COLS(COLS),
		.ROWS(ROWS),
		.HAS_SEQ(HAS_SEQ)
	) u_matrix (
		.clk(clk),
		.arst_n(arst_n),
		.col_arm(col_arm_ff),
		.seq_arm(seq_arm_ff),
		.row_strobe(row_strobe_ff),
		.gate_pos(gate_pos),
		.gate_neg(gate_neg),
		.seq_gate_pos(seq_gate_pos),
		.seq_gate_neg(seq_gate_neg)
	);

	// ------------------------------------------------------------
	// Coder, stepped by the local step pulse source
	// ------------------------------------------------------------
	sar_coder #(
		.BITS(BITS),
		.IW(IW)
	) u_coder (
		.clk(clk),
		.arst_n(arst_n),
		.code_step_pulse(step_pulse_ff),
		.step_idx(step_idx_ff),
		.err_pos(err_pos),
		.switch_on(switch_on),
		.code_word(code_word),
		.code_valid(code_valid)
	);

	assign col_arm = col_arm_ff;
	assign seq_col_arm = seq_arm_ff;
	assign row_strobe = row_strobe_ff;
	assign code_step_pulse = step_pulse_ff;
	assign code_chan = chan_ff;
	assign frame_start = frame_ff;

endmodule

`default_nettype wire

// ### sim/commutator_asserts.sv
/* Assertions on the commutator and coder top ports.
 Bound to the top module; one clock, sequencer column fitted. */
`default_nettype none
module commutator_asserts
	import commutator_pkg::*;
#(
	parameter int COLS = COLS_DEFAULT,
	parameter int ROWS = ROWS_DEFAULT,
	parameter int BITS = BITS_DEFAULT,
	parameter int PULSE_CYC = SAT_PULSE_CYC,
	parameter int GAP_CYC = STROBE_GAP_CYC
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic err_pos,
	input wire logic [COLS-1:0] col_arm,
	input wire logic seq_col_arm,
	input wire logic [ROWS-1:0] row_strobe,
	input wire logic [COLS*ROWS-1:0] gate_pos,
	input wire logic [COLS*ROWS-1:0] gate_neg,
	input wire logic [ROWS-1:0] seq_gate_pos,
	input wire logic [ROWS-1:0] seq_gate_neg,
	input wire logic code_step_pulse,
	input wire logic [BITS-1:0] switch_on,
	input wire logic [BITS-1:0] code_word,
	input wire logic code_valid
);
	// ----------------
	// Helper state
	// ----------------
	// Counters, not repetitions, so widths scale with PULSE_CYC
	logic [15:0] arm_cnt_ff, stb_cnt_ff, low_cnt_ff;
	logic [COLS-1:0] last_col_ff;
	logic [ROWS-1:0] stb_d_ff;
	logic trial_ff;
	logic [COLS*ROWS-1:0] exp_gate;
	for (genvar c = 0; c < COLS; c++) begin : g_exp
		assign exp_gate[c*ROWS +: ROWS] = {ROWS{last_col_ff[c]}} & stb_d_ff;
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			arm_cnt_ff <= 16'h0000;
			stb_cnt_ff <= 16'h0000;
			low_cnt_ff <= 16'h0000;
			last_col_ff <= '0;
			stb_d_ff <= '0;
			trial_ff <= 1'b0;
		end else begin
			arm_cnt_ff <= (|col_arm) ? arm_cnt_ff + 16'h0001 : 16'h0000;
			stb_cnt_ff <= (|row_strobe) ? stb_cnt_ff + 16'h0001 : 16'h0000;
			low_cnt_ff <= (|row_strobe) ? 16'h0000 : low_cnt_ff + 16'h0001;
			last_col_ff <= (|col_arm) ? col_arm : last_col_ff;
			stb_d_ff <= row_strobe;
			trial_ff <= (|row_strobe) | (trial_ff & ~code_step_pulse);
		end
	end
	// ----------------
	// Properties
	// ----------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	a_arm_width: assert property ($fell(|col_arm) |-> arm_cnt_ff == PULSE_CYC)
		else $error("arm pulse width wrong");
	a_strobe_width: assert property ($fell(|row_strobe) |-> stb_cnt_ff == PULSE_CYC)
		else $error("strobe pulse width wrong");
	a_strobe_gap: assert property ($rose(|row_strobe) |-> low_cnt_ff >= GAP_CYC)
		else $error("strobe gap too short");
	a_gate_cause: assert property (gate_pos == exp_gate && $onehot0(row_strobe))
		else $error("gate drive not from armed column strobe");
	a_seq_gate: assert property (seq_gate_pos == stb_d_ff)
		else $error("sequencer gate not following strobe");
	a_seq_arm: assert property ($onehot0(col_arm) && seq_col_arm == (|col_arm))
		else $error("sequencer column arm mismatch");
	a_diff_pair: assert property (gate_neg == gate_pos && seq_gate_neg == seq_gate_pos)
		else $error("plus and minus drives differ");
	a_bit_cause: assert property ((code_word & ~$past(code_word)) != '0 |->
		$past(code_step_pulse) && $past(err_pos, 2))
		else $error("word bit set without delayed decision");
	a_step_zero: assert property (code_step_pulse && trial_ff |=>
		switch_on == {1'b0, {(BITS-1){1'b1}}} && code_word == '0)
		else $error("start step left wrong switches");
	a_new_bits: assert property (code_step_pulse && !trial_ff |=>
		(switch_on & ~$past(switch_on)) == (code_word & ~$past(code_word)))
		else $error("switch and word bits disagree");
	a_valid_word: assert property (code_valid |-> $past(code_step_pulse) && switch_on == code_word ##1 !code_valid)
		else $error("valid pulse or final word wrong");
	a_word_hold: assert property (!$past(code_step_pulse) |-> $stable(code_word))
		else $error("word moved without step");
endmodule
`default_nettype wire

// ### sim/analog_sources.sv
/* Analog sources, ladder and comparator seen by the coder.
 Assumes the one-hot channel and step pulses of the top ports. */
`default_nettype none
module analog_sources #(
	parameter int CH = 6,
	parameter int BITS = 4
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [CH-1:0] code_chan,
	input wire logic code_step_pulse,
	input wire logic code_valid,
	output logic err_pos
);
	// ----------------
	// Ideal comparator
	// ----------------
	int k_ff;
	logic tog_ff;
	logic [BITS-1:0] level;
	// Channel i holds the low BITS bits of i*5, the last one full scale
	always_comb begin
		level = '0;
		for (int i = 0; i < CH; i++) begin
			if (code_chan[i]) level = (i == CH-1) ? '1 : BITS'(i*5);
		end
	end
	// Falling edge, so the answer settles well before the coder samples
	always_ff @(negedge clk or negedge arst_n) begin
		if (!arst_n) begin
			k_ff <= 0;
			tog_ff <= 1'b0;
		end else begin
			tog_ff <= ~tog_ff;
			if (code_valid) k_ff <= 0;
			else if (code_step_pulse) k_ff <= k_ff + 1;
		end
	end
	// Toggles outside decisions so a stale level never passes
	assign err_pos = (k_ff >= 1 && k_ff <= BITS) ? level[BITS-k_ff] : tog_ff;
endmodule
`default_nettype wire

// ### sim/tb.sv
/* Self-checking bench for the commutator and coder top.
 Assumes package, design, checker and model compiled first. */
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import commutator_pkg::*;
	localparam int C = 3;
	localparam int R = 2;
	localparam int B = 4;
	localparam int N = C*R;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic run = 1'b0;
	logic super_en = 1'b0;
	logic [C-1:0] super_cols = '0;
	logic [C-1:0] col_arm;
	logic [C-1:0] prev_arm_ff = '0;
	logic [R-1:0] row_strobe, seq_gate_pos, seq_gate_neg;
	logic [R-1:0] prev_stb_ff = '0;
	logic [N-1:0] gate_pos, gate_neg, code_chan;
	logic [N-1:0] prev_gate_ff = '0;
	logic [B-1:0] switch_on, code_word;
	logic err_pos, seq_col_arm, code_step_pulse, code_valid, frame_start;
	logic [B-1:0] got[$];
	logic [B-1:0] want[$];
	int arms[$];
	int rows[$];
	int gcnt[N];
	int n_mismatch = 0;
	int checked = 0;
	int cyc = 0;
	initial begin
		forever #25 clk = ~clk;
	end
	// Short pulse, gap and step counts keep frames near a hundred cycles
	matrix_commutator_sar_coder #(.COLS(C), .ROWS(R), .BITS(B), .HAS_SEQ(1'b1),
		.PULSE_CYC(2), .GAP_CYC(3), .STEP_CYC(2)) u_dut (
		.clk(clk), .arst_n(arst_n), .run(run), .super_en(super_en), .super_cols(super_cols),
		.err_pos(err_pos), .col_arm(col_arm), .seq_col_arm(seq_col_arm), .row_strobe(row_strobe),
		.gate_pos(gate_pos), .gate_neg(gate_neg), .seq_gate_pos(seq_gate_pos),
		.seq_gate_neg(seq_gate_neg), .code_step_pulse(code_step_pulse), .switch_on(switch_on),
		.code_word(code_word), .code_valid(code_valid), .code_chan(code_chan),
		.frame_start(frame_start));
	analog_sources #(.CH(N), .BITS(B)) u_src (.clk(clk), .arst_n(arst_n), .code_chan(code_chan),
		.code_step_pulse(code_step_pulse), .code_valid(code_valid), .err_pos(err_pos));
	// ----------------
	// Helpers
	// ----------------
	function automatic int idx(input logic [N-1:0] v);
		idx = 0;
		for (int i = 0; i < N; i++) begin
			if (v[i] === 1'b1) idx = i;
		end
	endfunction
	function automatic logic [B-1:0] level(input int i);
		level = (i == N-1) ? 4'hf : B'(i*5);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic wait_frame();
		@(negedge clk);
		while (frame_start !== 1'b1) @(negedge clk);
	endtask
	// ----------------
	// Monitor and timeout
	// ----------------
	always @(posedge clk) begin
		if (col_arm != '0 && prev_arm_ff == '0) arms.push_back(idx(N'(col_arm)));
		if (row_strobe != '0 && prev_stb_ff == '0) rows.push_back(idx(N'(row_strobe)));
		for (int i = 0; i < N; i++) begin
			if (gate_pos[i] && !prev_gate_ff[i]) gcnt[i]++;
		end
		if (code_valid === 1'b1) begin
			got.push_back(code_word);
			want.push_back(B'(idx(code_chan)));
		end
		prev_arm_ff <= col_arm;
		prev_stb_ff <= row_strobe;
		prev_gate_ff <= gate_pos;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	// ----------------
	// Scenarios
	// ----------------
	task automatic t_idle();
		repeat (10) @(negedge clk);
		check({col_arm, seq_col_arm, row_strobe, code_step_pulse, code_valid, frame_start, gate_pos, gate_neg,
			seq_gate_pos, switch_on, code_word}, '0);
	endtask
	task automatic t_frame(input logic sup, input logic [C-1:0] mask);
		int ea[$];
		super_en = sup;
		super_cols = mask;
		run = 1'b1;
		wait_frame();
		arms.delete();
		rows.delete();
		foreach (gcnt[i]) gcnt[i] = 0;
		// Last word of the previous frame lands two cycles into this one
		repeat (2) @(negedge clk);
		got.delete();
		want.delete();
		wait_frame();
		for (int c = 0; c < C; c++) begin
			ea.push_back(c);
			if (sup && mask[c]) ea.push_back(c);
		end
		check(arms.size(), ea.size());
		foreach (ea[i]) check(arms[i], ea[i]);
		check(rows.size(), ea.size() * R);
		foreach (rows[i]) check(rows[i], i % R);
		foreach (gcnt[i]) check(gcnt[i], (sup && mask[i/R]) ? 2 : 1);
		repeat (2) @(negedge clk);
		check(got.size(), ea.size() * R);
		check(got[0], '0);
		foreach (got[i]) begin
			check(got[i], level(ea[i/R] * R + i % R));
			check(want[i], ea[i/R] * R + i % R);
		end
	endtask
	task automatic t_stop();
		int seen;
		seen = 0;
		run = 1'b0;
		repeat (300) begin
			@(negedge clk);
			if (frame_start === 1'b1) seen++;
		end
		check(seen, 0);
		check({col_arm, row_strobe, code_step_pulse}, '0);
	endtask
	initial begin
		repeat (20) @(negedge clk);
		arst_n = 1'b1;
		t_idle();
		t_frame(1'b0, 3'b000);
		t_frame(1'b1, 3'b010);
		t_frame(1'b1, 3'b101);
		t_frame(1'b0, 3'b111);
		t_stop();
		report_and_stop();
	end
endmodule
bind matrix_commutator_sar_coder commutator_asserts #(.COLS(COLS), .ROWS(ROWS), .BITS(BITS),
	.PULSE_CYC(PULSE_CYC), .GAP_CYC(GAP_CYC)) u_chk (.clk(clk), .arst_n(arst_n),
	.err_pos(err_pos), .col_arm(col_arm), .seq_col_arm(seq_col_arm), .row_strobe(row_strobe),
	.gate_pos(gate_pos), .gate_neg(gate_neg), .seq_gate_pos(seq_gate_pos),
	.seq_gate_neg(seq_gate_neg), .code_step_pulse(code_step_pulse), .switch_on(switch_on),
	.code_word(code_word), .code_valid(code_valid));
`default_nettype wire
